// [design/dcd_regs.sv]
// Purpose: Debug context pointer and descriptor info register bank
// Assumes: Avalon-MM slave with waitrequest on the controller clock
// Notes: Every access is answered one cycle after it is first seen
`timescale 1ns/1ps
`default_nettype none
module dcd_regs (
   input wire logic clk,
   input wire logic srst,
   input wire logic [dcd_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [dcd_pkg::DATA_W-1:0] avs_writedata,
   output logic [dcd_pkg::DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [1:0] avs_response,
   input wire logic out_ep_stopped,
   input wire logic in_ep_stopped,
   output logic debug_enable_bit,
   output logic [63:0] info_ctx_addr,
   output logic [63:0] out_ep_ctx_addr,
   output logic [63:0] in_ep_ctx_addr,
   output logic out_ring_hw_owned,
   output logic in_ring_hw_owned,
   output dcd_pkg::dcd_xfer_t out_ep_kind,
   output dcd_pkg::dcd_xfer_t in_ep_kind,
   output logic [63:0] event_seg_table_base,
   output logic [7:0] protocol_code,
   output logic protocol_known,
   output logic [15:0] vendor_id,
   output logic [15:0] product_id,
   output logic [15:0] device_rev
);
   dcd_pkg::dcd_bus_t st_r;
   logic wait_r;
   logic [31:0] rdata_r;
   logic [1:0] resp_r;
   logic en_r;
   logic err_r;
   logic err_nxt;
   logic [63:0] info_addr_r;
   logic [7:0] proto_r;
   logic proto_ok_r;
   logic [31:0] ptr_lo;
   logic [31:0] ptr_hi;
   logic [31:0] info1;
   logic [31:0] info2;
   logic [31:0] erst_lo;
   logic [31:0] erst_hi;
   logic [63:0] ptr_full;
   logic [63:0] ctx_base;
   logic wr_acc;
   logic hit;
   logic [31:0] rd_mux;
   logic wr_ptr_lo;
   logic wr_ptr_hi;
   logic wr_info1;
   logic wr_info2;
   logic wr_erst_lo;
   logic wr_erst_hi;
   logic wr_ctrl;
   logic locked;
   logic en_set;
   logic err_set;
   logic err_clr;
   dcd_pkg::dcd_xfer_t out_kind_w;
   dcd_pkg::dcd_xfer_t in_kind_w;
   dcd_pkg::dcd_xfer_t out_kind_r;
   dcd_pkg::dcd_xfer_t in_kind_r;

   // Write commits only in the cycle waitrequest is low; the master still
   // holds address and data then, so no copy of them is needed
   assign wr_acc = avs_write & (st_r == dcd_pkg::BS_ACK);

   // Decode the byte address
   // Unmapped words read zero and answer with an error response
   always_comb begin
      hit = 1'b1;
      unique case (avs_address)
         dcd_pkg::OFS_ERST_LO: rd_mux = erst_lo;
         dcd_pkg::OFS_ERST_HI: rd_mux = erst_hi;
         dcd_pkg::OFS_CTRL: rd_mux = {30'h0000_0000, err_r, en_r};
         dcd_pkg::OFS_PTR_LO: rd_mux = ptr_lo;
         dcd_pkg::OFS_PTR_HI: rd_mux = ptr_hi;
         dcd_pkg::OFS_INFO1: rd_mux = info1;
         dcd_pkg::OFS_INFO2: rd_mux = info2;
         default: begin
            rd_mux = 32'h0000_0000;
            hit = 1'b0;
         end
      endcase
   end

   // Bus handshake: idle with waitrequest high, one acknowledge cycle
   // Every access costs one wait cycle; going back to idle after the
   // answer keeps a request held at that edge from being taken twice
   always_ff @(posedge clk) begin
      if (srst) begin
         st_r <= dcd_pkg::BS_IDLE;
         wait_r <= 1'b1;
      end else begin
         unique case (st_r)
            dcd_pkg::BS_IDLE: begin
               if (avs_read | avs_write) begin
                  st_r <= dcd_pkg::BS_ACK;
                  wait_r <= 1'b0;
               end
            end
            dcd_pkg::BS_ACK: begin
               st_r <= dcd_pkg::BS_IDLE;
               wait_r <= 1'b1;
            end
         endcase
      end
   end

   // Read data and response captured as the request is first seen
   // A write in the acknowledge cycle therefore cannot tear a read
   always_ff @(posedge clk) begin
      if (srst) begin
         rdata_r <= 32'h0000_0000;
         resp_r <= dcd_pkg::RESP_OKAY;
      end else if (st_r == dcd_pkg::BS_IDLE && (avs_read | avs_write)) begin
         rdata_r <= avs_read ? rd_mux : 32'h0000_0000;
         resp_r <= hit ? dcd_pkg::RESP_OKAY : dcd_pkg::RESP_SLVERR;
      end
   end

   // [RULE15] lock structures while enabled
   // Locked writes are dropped but still answered OKAY, so software
   // sees no fault; the control word itself never locks
   assign locked = en_r;
   assign wr_ptr_lo = wr_acc & ~locked & (avs_address == dcd_pkg::OFS_PTR_LO);
   assign wr_ptr_hi = wr_acc & ~locked & (avs_address == dcd_pkg::OFS_PTR_HI);
   assign wr_info1 = wr_acc & ~locked & (avs_address == dcd_pkg::OFS_INFO1);
   assign wr_info2 = wr_acc & ~locked & (avs_address == dcd_pkg::OFS_INFO2);
   assign wr_erst_lo = wr_acc & ~locked &
      (avs_address == dcd_pkg::OFS_ERST_LO);
   assign wr_erst_hi = wr_acc & ~locked &
      (avs_address == dcd_pkg::OFS_ERST_HI);
   assign wr_ctrl = wr_acc & (avs_address == dcd_pkg::OFS_CTRL);

   // [RULE2] pointer low word
   // [RULE17] preserve bits stored
   // Bits 3:0 are kept for read back but never reach an address
   dcd_reg_word #(
      .RESET(dcd_pkg::RST_ZERO),
      .WMASK(dcd_pkg::WM_ALL)
   ) u_ptr_lo (
      .clk(clk),
      .srst(srst),
      .wr_en(wr_ptr_lo),
      .byteen(avs_byteenable),
      .wdata(avs_writedata),
      .q(ptr_lo)
   );

   // [RULE2] pointer high word
   // High word has no reserved bits
   dcd_reg_word #(
      .RESET(dcd_pkg::RST_ZERO),
      .WMASK(dcd_pkg::WM_ALL)
   ) u_ptr_hi (
      .clk(clk),
      .srst(srst),
      .wr_en(wr_ptr_hi),
      .byteen(avs_byteenable),
      .wdata(avs_writedata),
      .q(ptr_hi)
   );

   // [RULE9] info one word
   // [RULE5] bits 15:8 read zero
   // Clearing 15:8 in the mask keeps stray writes from reading back
   dcd_reg_word #(
      .RESET(dcd_pkg::RST_ZERO),
      .WMASK(dcd_pkg::WM_INFO1)
   ) u_info1 (
      .clk(clk),
      .srst(srst),
      .wr_en(wr_info1),
      .byteen(avs_byteenable),
      .wdata(avs_writedata),
      .q(info1)
   );

   // [RULE9] info two word
   // Product and revision halves have no reserved bits
   dcd_reg_word #(
      .RESET(dcd_pkg::RST_ZERO),
      .WMASK(dcd_pkg::WM_ALL)
   ) u_info2 (
      .clk(clk),
      .srst(srst),
      .wr_en(wr_info2),
      .byteen(avs_byteenable),
      .wdata(avs_writedata),
      .q(info2)
   );

   // [RULE14] segment table base, 64-byte aligned
   // Masking in storage means software reads back what hardware uses
   dcd_reg_word #(
      .RESET(dcd_pkg::RST_ZERO),
      .WMASK(dcd_pkg::WM_ERST_LO)
   ) u_erst_lo (
      .clk(clk),
      .srst(srst),
      .wr_en(wr_erst_lo),
      .byteen(avs_byteenable),
      .wdata(avs_writedata),
      .q(erst_lo)
   );

   // [RULE14] segment table base, high word
   dcd_reg_word #(
      .RESET(dcd_pkg::RST_ZERO),
      .WMASK(dcd_pkg::WM_ALL)
   ) u_erst_hi (
      .clk(clk),
      .srst(srst),
      .wr_en(wr_erst_hi),
      .byteen(avs_byteenable),
      .wdata(avs_writedata),
      .q(erst_hi)
   );

   // [RULE1] align away bits 3:0
   // Aligning here rather than in storage keeps the stored bits readable
   assign ptr_full = {ptr_hi, ptr_lo};
   assign ctx_base = ptr_full & dcd_pkg::PTR_ALIGN;

   // Enable bit in the control word, low byte only
   // A control write without byte lane 0 leaves both bits alone
   assign en_set = wr_ctrl & avs_byteenable[0] &
      avs_writedata[dcd_pkg::CTRL_EN_BIT];
   always_ff @(posedge clk) begin
      if (srst) begin
         en_r <= 1'b0;
      end else if (wr_ctrl & avs_byteenable[0]) begin
         en_r <= avs_writedata[dcd_pkg::CTRL_EN_BIT];
      end
   end

   // [RULE3] flag enable with null pointer
   // Sticky, write one to clear; a new set wins over the clear
   // Testing the aligned pointer also catches a base of bits 3:0 only
   assign err_set = en_set & ~en_r & (ctx_base == 64'h0000_0000_0000_0000);
   assign err_clr = wr_ctrl & avs_byteenable[0] &
      avs_writedata[dcd_pkg::CTRL_ERR_BIT];
   always_comb begin
      err_nxt = err_set | (err_r & ~err_clr);
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         err_r <= 1'b0;
      end else begin
         err_r <= err_nxt;
      end
   end

   // [RULE11] info context at stride zero
   // [RULE12] stride fixed, size select ignored
   // The stride is a constant so the controller's own context size
   // selection has no path into the debug layout
   always_ff @(posedge clk) begin
      if (srst) begin
         info_addr_r <= 64'h0000_0000_0000_0000;
      end else begin
         info_addr_r <= ctx_base + (dcd_pkg::CTX_STRIDE &
            64'h0000_0000_0000_0000);
      end
   end

   // [RULE10] OUT endpoint context
   // Each endpoint slot adds its fixed offset to the aligned base
   dcd_ep_ctx #(
      .OFFSET(dcd_pkg::OUT_EP_OFS)
   ) u_ep_out (
      .clk(clk),
      .srst(srst),
      .base(ctx_base),
      .enable(en_r),
      .stopped(out_ep_stopped),
      .ctx_addr(out_ep_ctx_addr),
      .hw_owns_ring(out_ring_hw_owned),
      .xfer_kind(out_kind_w)
   );

   // [RULE10] IN endpoint context
   dcd_ep_ctx #(
      .OFFSET(dcd_pkg::IN_EP_OFS)
   ) u_ep_in (
      .clk(clk),
      .srst(srst),
      .base(ctx_base),
      .enable(en_r),
      .stopped(in_ep_stopped),
      .ctx_addr(in_ep_ctx_addr),
      .hw_owns_ring(in_ring_hw_owned),
      .xfer_kind(in_kind_w)
   );

   // [RULE13] ring kinds held in flops
   // Keeps every top-level output registered like the rest of the bank
   always_ff @(posedge clk) begin
      if (srst) begin
         out_kind_r <= dcd_pkg::XK_BULK;
         in_kind_r <= dcd_pkg::XK_BULK;
      end else begin
         out_kind_r <= out_kind_w;
         in_kind_r <= in_kind_w;
      end
   end

   // [RULE4] protocol code and reserved check
   // Reserved codes are still stored; protocol_known only flags them
   always_ff @(posedge clk) begin
      if (srst) begin
         proto_r <= 8'h00;
         proto_ok_r <= 1'b1;
      end else begin
         proto_r <= info1[dcd_pkg::PROTO_MSB:dcd_pkg::PROTO_LSB];
         proto_ok_r <= info1[dcd_pkg::PROTO_MSB:dcd_pkg::PROTO_LSB] <
            dcd_pkg::PROTO_FIRST_RSVD;
      end
   end

   // Port drives; every one of them comes from a flip-flop
   assign avs_readdata = rdata_r;
   assign avs_waitrequest = wait_r;
   assign avs_response = resp_r;
   assign debug_enable_bit = en_r;
   assign info_ctx_addr = info_addr_r;
   assign event_seg_table_base = {erst_hi, erst_lo};
   assign protocol_code = proto_r;
   assign protocol_known = proto_ok_r;
   assign out_ep_kind = out_kind_r;
   assign in_ep_kind = in_kind_r;
   // Descriptor fields follow a write on the edge that commits it
   // [RULE5] vendor from upper half
   assign vendor_id = info1[dcd_pkg::HI_MSB:dcd_pkg::HI_LSB];
   // [RULE7] product from lower half
   assign product_id = info2[dcd_pkg::LO_MSB:0];
   // [RULE8] revision from upper half
   assign device_rev = info2[dcd_pkg::HI_MSB:dcd_pkg::HI_LSB];
endmodule
`default_nettype wire

// [include/dcd_pkg.sv]
// Purpose: Constants for the debug context and descriptor register bank
// Assumes: Avalon-MM byte addresses, 32-bit data, one word per register
// Notes: Names every offset, mask and field the bank uses
// Overview of operation
// [RULE1] Pointer bits 63:4 hold context address
// [RULE2] 64-bit RW pointer at 30h, resets zero
// [RULE3] Software loads pointer before setting enable
// [RULE4] Info one 7:0 is debug protocol code
// [RULE5] Info one 31:16 vendor, 15:8 read zero
// [RULE6] Software programs both info registers before enable
// [RULE7] Info two 15:0 holds product identifier
// [RULE8] Info two 31:16 holds device revision
// [RULE9] Info registers at 38h and 3Ch, reset zero
// [RULE10] Info context, OUT at 40h, IN 80h
// [RULE11] Every debug structure is 64 bytes long
// [RULE12] Controller context size selection never applies here
// [RULE13] Both transfer rings handled as bulk endpoints
// [RULE14] Event ring registers behave like normal ones
// [RULE15] Controller owns structures while enable is set
// [RULE16] Stopped endpoint hands its ring to software
// [RULE17] Reserved-zero reads zero, reserved-preserve returns written
package dcd_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   // Register byte offsets
   localparam logic [7:0] OFS_ERST_LO = 8'h10;
   localparam logic [7:0] OFS_ERST_HI = 8'h14;
   localparam logic [7:0] OFS_CTRL = 8'h20;
   localparam logic [7:0] OFS_PTR_LO = 8'h30;
   localparam logic [7:0] OFS_PTR_HI = 8'h34;
   localparam logic [7:0] OFS_INFO1 = 8'h38;
   localparam logic [7:0] OFS_INFO2 = 8'h3C;
   // Reset values
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   // Writable masks; cleared bits are reserved-zero
   localparam logic [31:0] WM_ALL = 32'hFFFF_FFFF;
   localparam logic [31:0] WM_INFO1 = 32'hFFFF_00FF;
   localparam logic [31:0] WM_ERST_LO = 32'hFFFF_FFC0;
   // Address alignment masks
   localparam logic [63:0] PTR_ALIGN = 64'hFFFF_FFFF_FFFF_FFF0;
   // Control register fields
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_ERR_BIT = 1;
   // Descriptor field positions
   localparam int PROTO_LSB = 0;
   localparam int PROTO_MSB = 7;
   localparam int HI_LSB = 16;
   localparam int HI_MSB = 31;
   localparam int LO_MSB = 15;
   localparam logic [7:0] PROTO_FIRST_RSVD = 8'h02;
   // Context layout
   localparam logic [63:0] CTX_STRIDE = 64'h0000_0000_0000_0040;
   localparam logic [63:0] OUT_EP_OFS = 64'h0000_0000_0000_0040;
   localparam logic [63:0] IN_EP_OFS = 64'h0000_0000_0000_0080;
   // Avalon response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      XK_CTRL = 2'h0,
      XK_ISOC = 2'h1,
      XK_BULK = 2'h2,
      XK_INTR = 2'h3
   } dcd_xfer_t;
   typedef enum logic [0:0] {
      BS_IDLE = 1'h0,
      BS_ACK = 1'h1
   } dcd_bus_t;
endpackage

// [design/dcd_reg_word.sv]
// Purpose: One 32-bit software register word with byte enables
// Assumes: Write strobe comes from the bus slave on the same clock
// Notes: Bits cleared in WMASK hold zero and ignore writes
`timescale 1ns/1ps
`default_nettype none
module dcd_reg_word #(
   parameter logic [31:0] RESET = 32'h0000_0000,
   parameter logic [31:0] WMASK = 32'hFFFF_FFFF
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic wr_en,
   input wire logic [3:0] byteen,
   input wire logic [31:0] wdata,
   output logic [31:0] q
);
   logic [31:0] q_r;
   logic [31:0] lane_m;

   // Expand byte enables to a bit mask
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         lane_m[i*8 +: 8] = {8{byteen[i]}};
      end
   end

   // Masked byte write; reserved-zero bits never leave zero
   always_ff @(posedge clk) begin
      if (srst) begin
         q_r <= RESET & WMASK;
      end else if (wr_en) begin
         q_r <= ((wdata & lane_m) | (q_r & ~lane_m)) & WMASK;
      end
   end

   assign q = q_r;
endmodule
`default_nettype wire

// [design/dcd_ep_ctx.sv]
// Purpose: Address and ring ownership of one debug endpoint context
// Assumes: Base is already 16-byte aligned; stopped is same-clock logic
// Notes: Address and ownership outputs are registered, one cycle behind their inputs; the ring kind is a constant
`timescale 1ns/1ps
`default_nettype none
module dcd_ep_ctx #(
   parameter logic [63:0] OFFSET = 64'h0000_0000_0000_0040
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [63:0] base,
   input wire logic enable,
   input wire logic stopped,
   output logic [63:0] ctx_addr,
   output logic hw_owns_ring,
   output dcd_pkg::dcd_xfer_t xfer_kind
);
   logic [63:0] addr_r;
   logic own_r;

   // [RULE10] fixed slot offset
   always_ff @(posedge clk) begin
      if (srst) begin
         addr_r <= 64'h0000_0000_0000_0000;
      end else begin
         addr_r <= base + OFFSET;
      end
   end

   // [RULE15] hardware owns while enabled
   // [RULE16] stopped releases ring
   always_ff @(posedge clk) begin
      if (srst) begin
         own_r <= 1'b0;
      end else begin
         own_r <= enable & ~stopped;
      end
   end

   assign ctx_addr = addr_r;
   assign hw_owns_ring = own_r;
   // [RULE13] always bulk ring
   assign xfer_kind = dcd_pkg::XK_BULK;
endmodule
`default_nettype wire

// [tb/dcd_regs_asserts.sv]
// Purpose: Bus timing and context address checks on dcd_regs ports
// Assumes: One clock domain, srst synchronous and active high
// Notes: Derived outputs are compared one edge after their sources
`timescale 1ns/1ps
`default_nettype none
module dcd_regs_chk (
   input wire logic clk,
   input wire logic srst,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic out_ep_stopped,
   input wire logic in_ep_stopped,
   input wire logic debug_enable_bit,
   input wire logic [63:0] info_ctx_addr,
   input wire logic [63:0] out_ep_ctx_addr,
   input wire logic [63:0] in_ep_ctx_addr,
   input wire logic out_ring_hw_owned,
   input wire logic in_ring_hw_owned,
   input wire dcd_pkg::dcd_xfer_t out_ep_kind,
   input wire dcd_pkg::dcd_xfer_t in_ep_kind,
   input wire logic [63:0] event_seg_table_base,
   input wire logic [15:0] vendor_id,
   input wire logic [15:0] product_id,
   input wire logic [15:0] device_rev
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   // Bus answers after exactly one wait cycle and holds it one cycle
   a_wait_one_cycle: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not answered after one wait cycle");
   a_ack_one_cycle: assert property (
      !avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low longer than one cycle");
   a_idle_no_ack: assert property (
      !avs_read && !avs_write |=> avs_waitrequest)
      else $error("answer without a request");
   // Context layout; offset and ownership checks skipped on the first edge after reset
   a_out_ctx_offset: assert property (
      !$past(srst) |-> out_ep_ctx_addr == info_ctx_addr + 64'h40)
      else $error("OUT context not 40h past info context");
   a_in_ctx_offset: assert property (
      !$past(srst) |-> in_ep_ctx_addr == out_ep_ctx_addr + 64'h40)
      else $error("IN context not 64 bytes past OUT context");
   a_ptr_aligned: assert property (
      info_ctx_addr[3:0] == 4'h0)
      else $error("context address not 16-byte aligned");
   a_kind_bulk: assert property (
      out_ep_kind == dcd_pkg::XK_BULK && in_ep_kind == dcd_pkg::XK_BULK)
      else $error("endpoint kind not bulk");
   a_ring_owner: assert property (
      !$past(srst) |-> out_ring_hw_owned ==
      ($past(debug_enable_bit) && !$past(out_ep_stopped)) &&
      in_ring_hw_owned == ($past(debug_enable_bit) && !$past(in_ep_stopped)))
      else $error("ring ownership wrong");
   a_evt_aligned: assert property (
      event_seg_table_base[5:0] == 6'h00)
      else $error("segment table base low bits not zero");
   // A committed write while enabled leaves the info and event segment table words alone
   a_info_locked: assert property (
      debug_enable_bit && avs_write && !avs_waitrequest |=>
      $stable(vendor_id) && $stable(product_id) && $stable(device_rev) &&
      $stable(event_seg_table_base))
      else $error("locked register changed while enabled");
endmodule
bind dcd_regs dcd_regs_chk i_dcd_regs_chk (.clk, .srst, .avs_read,
   .avs_write, .avs_waitrequest, .out_ep_stopped, .in_ep_stopped,
   .debug_enable_bit, .info_ctx_addr, .out_ep_ctx_addr, .in_ep_ctx_addr,
   .out_ring_hw_owned, .in_ring_hw_owned, .out_ep_kind, .in_ep_kind,
   .event_seg_table_base, .vendor_id, .product_id, .device_rev);
`default_nettype wire

// [tb/test_debug_context_descriptor_regs.sv]
// Purpose: Self-checking bench for the context and descriptor registers
// Assumes: Avalon-MM master driven on rising edges, full byte lanes
// Notes: Each scenario task drives the bus and judges the result
`timescale 1ns/1ps
`default_nettype none
module test_debug_context_descriptor_regs;
   logic clk, srst, avs_read, avs_write, avs_waitrequest;
   logic out_ep_stopped, in_ep_stopped, debug_enable_bit;
   logic protocol_known, out_ring_hw_owned, in_ring_hw_owned;
   logic [7:0] avs_address, protocol_code;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata;
   logic [1:0] avs_response, resp;
   logic [63:0] info_ctx_addr, out_ep_ctx_addr, in_ep_ctx_addr, evt;
   logic [15:0] vendor_id, product_id, device_rev;
   dcd_pkg::dcd_xfer_t out_ep_kind, in_ep_kind;
   int n_fail = 0;
   int tests_run = 0;
   dcd_regs i_dcd_regs (.clk, .srst, .avs_address, .avs_read, .avs_write,
      .avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest,
      .avs_response, .out_ep_stopped, .in_ep_stopped, .debug_enable_bit,
      .info_ctx_addr, .out_ep_ctx_addr, .in_ep_ctx_addr, .out_ring_hw_owned,
      .in_ring_hw_owned, .out_ep_kind, .in_ep_kind,
      .event_seg_table_base(evt), .protocol_code, .protocol_known,
      .vendor_id, .product_id, .device_rev);
   // Free-running 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic check(input string nm, input logic [63:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One bus cycle; the idle edge first keeps requests apart
   task automatic bus(input logic wr, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      // A request never answered ends the run as a failure
      if (avs_waitrequest !== 1'b0) begin
         n_fail++;
         complete_run();
      end else begin
         rd = avs_readdata;
         resp = avs_response;
         avs_write <= 1'b0;
         avs_read <= 1'b0;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask
   // Read and compare, then let derived outputs settle
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] x;
      bus(1'b0, a, 32'h0000_0000, x);
      check("readdata", {32'h0, x}, {32'h0, e});
      repeat (2) @(posedge clk);
   endtask
   task automatic t_reset();
      rd(8'h30, 32'h0000_0000);
      check("resp ok", resp, 64'h0);
      rd(8'h34, 32'h0000_0000);
      rd(8'h38, 32'h0000_0000);
      rd(8'h3C, 32'h0000_0000);
      check("known", protocol_known, 64'h1);
      check("enable", debug_enable_bit, 64'h0);
   endtask
   task automatic t_pointer();
      wr(8'h30, 32'h1234_5679);
      wr(8'h34, 32'h0000_00AB);
      rd(8'h30, 32'h1234_5679);
      rd(8'h34, 32'h0000_00AB);
      check("info", info_ctx_addr, 64'h0000_00AB_1234_5670);
      check("out", out_ep_ctx_addr, 64'h0000_00AB_1234_56B0);
      check("in", in_ep_ctx_addr, 64'h0000_00AB_1234_56F0);
   endtask
   task automatic t_info();
      logic [7:0] p[4] = '{8'h00, 8'h01, 8'h02, 8'hFF};
      foreach (p[i]) begin
         wr(8'h38, {16'h5A3C, 8'hFF, p[i]});
         rd(8'h38, {16'h5A3C, 8'h00, p[i]});
         check("proto", protocol_code, p[i]);
         check("known", protocol_known, p[i] < 8'h02);
         check("vendor", vendor_id, 64'h5A3C);
      end
      wr(8'h3C, 32'h0102_4321);
      rd(8'h3C, 32'h0102_4321);
      check("product", product_id, 64'h4321);
      check("rev", device_rev, 64'h0102);
   endtask
   task automatic t_event_unmapped();
      wr(8'h10, 32'hFFFF_FFFF);
      wr(8'h14, 32'h0000_0001);
      rd(8'h10, 32'hFFFF_FFC0);
      check("evt", evt, 64'h0000_0001_FFFF_FFC0);
      wr(8'h40, 32'hFFFF_FFFF);
      rd(8'h40, 32'h0000_0000);
      check("resp", resp, 64'h2);
   endtask
   task automatic t_enable();
      wr(8'h20, 32'h0000_0001);
      rd(8'h20, 32'h0000_0001);
      check("enable", debug_enable_bit, 64'h1);
      check("owned", out_ring_hw_owned, 64'h1);
      wr(8'h38, 32'h0000_0001);
      wr(8'h30, 32'h0000_0000);
      rd(8'h38, 32'h5A3C_00FF);
      rd(8'h30, 32'h1234_5679);
      out_ep_stopped <= 1'b1;
      repeat (3) @(posedge clk);
      check("out owned", out_ring_hw_owned, 64'h0);
      check("in owned", in_ring_hw_owned, 64'h1);
      check("kind", out_ep_kind, dcd_pkg::XK_BULK);
      check("in kind", in_ep_kind, dcd_pkg::XK_BULK);
      out_ep_stopped <= 1'b0;
      wr(8'h20, 32'h0000_0000);
      wr(8'h38, 32'h0000_0001);
      rd(8'h38, 32'h0000_0001);
      check("in owned", in_ring_hw_owned, 64'h0);
      check("enable", debug_enable_bit, 64'h0);
   endtask
   // Enable with a null pointer raises the sticky error; set beats clear
   task automatic t_null_enable();
      wr(8'h30, 32'h0000_0000);
      wr(8'h34, 32'h0000_0000);
      wr(8'h20, 32'h0000_0001);
      rd(8'h20, 32'h0000_0003);
      wr(8'h20, 32'h0000_0002);
      rd(8'h20, 32'h0000_0000);
      check("resp ok", resp, 64'h0);
      wr(8'h20, 32'h0000_0003);
      rd(8'h20, 32'h0000_0003);
      wr(8'h20, 32'h0000_0002);
      rd(8'h20, 32'h0000_0000);
   endtask
   // Reset in mid-run clears the info and event segment table words again
   task automatic t_midreset();
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      rd(8'h38, 32'h0000_0000);
      rd(8'h3C, 32'h0000_0000);
      rd(8'h10, 32'h0000_0000);
      check("evt", evt, 64'h0);
      check("known", protocol_known, 64'h1);
      check("enable", debug_enable_bit, 64'h0);
   endtask
   // Reset for twelve cycles, then the scenarios in turn
   initial begin
      srst = 1'b1;
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_byteenable = 4'hF;
      avs_writedata = 32'h0000_0000;
      out_ep_stopped = 1'b0;
      in_ep_stopped = 1'b0;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      t_reset();
      t_pointer();
      t_info();
      t_event_unmapped();
      t_enable();
      t_null_enable();
      t_midreset();
      complete_run();
   end
endmodule
`default_nettype wire
